// *** tb_timer_event_flags_and_sw_events.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_timer_event_flags_and_sw_events;
    // ==========================================================
    // Signals and design
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [tef_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hw_ovf = 1'b0;
    logic reinit = 1'b0;
    logic ovf_dis = 1'b0;
    logic ovf_src = 1'b0;
    logic [3:0] ch_hw = 4'h0;
    logic [3:0] in_mode = 4'h0;
    logic [3:0] val_rd = 4'h0;
    logic trg_in = 1'b0;
    logic trg_fall = 1'b0;
    logic susp = 1'b0;
    logic trg_ev;
    logic ovf_ev;
    logic [3:0] ch_ev;
    logic [15:0] st;
    logic [31:0] r;
    logic err;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    // Software event writes, event pulses {trg,ovf,ch}, status after
    logic [15:0] row_sw [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0040, 16'h0000, 16'h0041, 16'h005f};
    logic [5:0] row_ev [9] = '{6'h10, 6'h01, 6'h02, 6'h04, 6'h08, 6'h20,
        6'h00, 6'h30, 6'h3f};
    logic [15:0] row_st [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0010, 16'h0040, 16'h0000, 16'h0041, 16'h005f};

    tef_event_flags uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_overflow(hw_ovf),
        .cnt_reinit_by_trigger(reinit), .overflow_event_disable(ovf_dis),
        .overflow_source_select(ovf_src), .ch_hw_event(ch_hw),
        .ch_input_mode(in_mode), .ch_value_read(val_rd),
        .selected_trigger_input(trg_in), .trigger_falling_active(trg_fall),
        .suspend_mode(susp), .trigger_event(trg_ev),
        .overflow_event(ovf_ev), .ch_event(ch_ev), .event_status(st));

    always #2 pclk = ~pclk;

    // ==========================================================
    // Tasks
    task results;
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task chk_ev(input logic [5:0] e);
        check_count++;
        if ({trg_ev, ovf_ev, ch_ev} !== e) begin
            mismatches++;
            $display("wrong value events expected %h seen %h", e,
                {trg_ev, ovf_ev, ch_ev});
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_st(input logic [15:0] e);
        apb(1'b0, tef_pkg::STATUS_ADDR, 32'h0000_0000);
        chk("status", {16'h0000, e}, r);
        chk("event_status", {16'h0000, e}, {16'h0000, st});
    endtask

    task pulse(input logic [3:0] c, input logic [3:0] v, input logic o,
        input logic ri);
        @(posedge pclk);
        ch_hw <= c;
        val_rd <= v;
        hw_ovf <= o;
        reinit <= ri;
        @(posedge pclk);
        ch_hw <= 4'h0;
        val_rd <= 4'h0;
        hw_ovf <= 1'b0;
        reinit <= 1'b0;
    endtask

    task trg(input logic lvl, input logic f, input logic s,
        input logic [5:0] e);
        @(posedge pclk);
        trg_in <= lvl;
        trg_fall <= f;
        susp <= s;
        #1 chk_ev(e);
    endtask

    // ==========================================================
    // Sequence
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_st(16'h0000);
        apb(1'b0, tef_pkg::SWEVT_ADDR, 32'h0000_0000);
        chk("swevt", 32'h0000_0000, r);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0000);
            apb(1'b1, tef_pkg::SWEVT_ADDR, {16'h0000, row_sw[i]});
            #1 chk_ev(row_ev[i]);
            rd_st(row_st[i]);
        end
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0000);
        // Capture twice in input mode, then clear one flag at a time
        in_mode <= 4'hf;
        pulse(4'hf, 4'h0, 1'b0, 1'b0);
        pulse(4'hf, 4'h0, 1'b0, 1'b0);
        rd_st(16'h1e1e);
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_1c5f);
        rd_st(16'h1c1e);
        pulse(4'h0, 4'h1, 1'b0, 1'b0);
        rd_st(16'h1c1c);
        in_mode <= 4'h0;
        pulse(4'h0, 4'h2, 1'b0, 1'b0);
        rd_st(16'h1c1c);
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0000);
        // Overflow sources against the two control bits
        ovf_dis <= 1'b1;
        pulse(4'h0, 4'h0, 1'b1, 1'b0);
        rd_st(16'h0001);
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0000);
        pulse(4'h0, 4'h0, 1'b0, 1'b1);
        rd_st(16'h0000);
        apb(1'b1, tef_pkg::SWEVT_ADDR, 32'h0000_0001);
        #1 chk_ev(6'h10);
        rd_st(16'h0000);
        ovf_dis <= 1'b0;
        ovf_src <= 1'b1;
        pulse(4'h0, 4'h0, 1'b0, 1'b1);
        rd_st(16'h0000);
        ovf_src <= 1'b0;
        pulse(4'h0, 4'h0, 1'b0, 1'b1);
        rd_st(16'h0001);
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0000);
        // Trigger edges: active edge only, any edge in suspend
        trg(1'b1, 1'b0, 1'b0, 6'h20);
        trg(1'b0, 1'b0, 1'b0, 6'h00);
        trg(1'b1, 1'b1, 1'b0, 6'h00);
        trg(1'b0, 1'b1, 1'b0, 6'h20);
        trg(1'b1, 1'b1, 1'b1, 6'h20);
        trg(1'b0, 1'b1, 1'b1, 6'h20);
        rd_st(16'h0040);
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0040);
        rd_st(16'h0040);
        // Clear written in the same cycle as a hardware overflow
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= tef_pkg::STATUS_ADDR;
        pwdata <= 32'h0000_0000;
        @(posedge pclk);
        penable <= 1'b1;
        hw_ovf <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        hw_ovf <= 1'b0;
        rd_st(16'h0001);
        // Lane 0 strobe off leaves the low flag byte alone
        pstrb <= 4'h2;
        apb(1'b1, tef_pkg::STATUS_ADDR, 32'h0000_0000);
        pstrb <= 4'hf;
        rd_st(16'h0001);
        // Unmapped address is refused and leaves flags alone
        apb(1'b1, 12'h008, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
        chk("pready", 32'h0000_0001, {31'h0, pready});
        rd_st(16'h0001);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, r);
        // Reset in mid-run clears every flag
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("status in reset", 32'h0000_0000, {16'h0000, st});
        presetn <= 1'b1;
        rd_st(16'h0000);
        results();
    end
endmodule

`default_nettype wire

// *** tef_event_flags.sv ***
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Channel 1 recapture flag set on repeat capture
// - Channels 2-4 recapture flags at bits 10-12
// - Write zero clears flag; one leaves it
// - Trigger flag bit 6 set by trigger event
// - Trigger on active edge, any edge when suspended
// - Input mode channel 1 flag set on capture
// - Input mode flag cleared by write or read
// - Output mode flag set on compare, software clears
// - Channels 2-4 event flags at bits 2-4
// - Overflow flag bit 0 set by overflow event
// - Software overflow sets flag when both controls zero
// - Trigger reinit sets overflow flag, same condition
// - Software event bit 6 generates trigger event
// - Software event bits 1-4 generate channel events
// - Software event bit 0 generates overflow event
// - Reserved bits read zero, writes ignored
module tef_event_flags #(
    parameter int NUM_CH = tef_pkg::NUM_CH
) (
    input wire logic pclk, // Bus and timer clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [tef_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic hw_overflow, // Counter overflow pulse
    input wire logic cnt_reinit_by_trigger, // Counter reinit by trigger
    input wire logic overflow_event_disable, // Control bit from ctrl reg
    input wire logic overflow_source_select, // Control bit from ctrl reg
    input wire logic [NUM_CH-1:0] ch_hw_event, // Capture/compare pulses
    input wire logic [NUM_CH-1:0] ch_input_mode, // High when channel input
    input wire logic [NUM_CH-1:0] ch_value_read, // Capture value reg read
    input wire logic selected_trigger_input, // Selected trigger level
    input wire logic trigger_falling_active, // High: falling is active
    input wire logic suspend_mode, // High in suspend slave mode
    output logic trigger_event, // Trigger event pulse
    output logic overflow_event, // Overflow event pulse
    output logic [NUM_CH-1:0] ch_event, // Channel event pulses
    output logic [15:0] event_status // Status register value
);
    localparam int NF = tef_pkg::NUM_FLAGS;

    logic setup_ph;
    logic access_ph;
    logic hit_status;
    logic hit_swevt;
    logic status_wr;
    logic swevt_wr;
    logic [15:0] wmask;
    logic [tef_pkg::SW_W-1:0] sw_d;
    logic [tef_pkg::SW_W-1:0] sw_q;
    logic trig_prev_d;
    logic trig_prev_q;
    logic trig_rise;
    logic trig_fall;
    logic ovf_flag_ok;
    logic [NUM_CH-1:0] cap_evt;
    logic [NF-1:0] fl_set;
    logic [NF-1:0] fl_clr;
    logic [NF-1:0] fl_q;
    logic [15:0] status_v;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // ===================================================
    // APB decode
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign pready = 1'b1;

    always_comb begin
        hit_status = 1'b0;
        hit_swevt = 1'b0;
        if (paddr == tef_pkg::STATUS_ADDR) begin
            hit_status = 1'b1;
        end else if (paddr == tef_pkg::SWEVT_ADDR) begin
            hit_swevt = 1'b1;
        end
    end

    assign pslverr = access_ph && !hit_status && !hit_swevt;
    assign status_wr = access_ph && pwrite && hit_status;
    assign swevt_wr = access_ph && pwrite && hit_swevt;
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // ===================================================
    // Software event requests, one-cycle pulses
    always_comb begin
        sw_d = tef_pkg::SWEVT_RST;
        if (swevt_wr) begin
            sw_d = pwdata[tef_pkg::SW_W-1:0] & wmask[tef_pkg::SW_W-1:0]
                & tef_pkg::SWEVT_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_q <= tef_pkg::SWEVT_RST;
        end else begin
            sw_q <= sw_d;
        end
    end

    // ===================================================
    // Trigger edge detection
    always_comb begin
        trig_prev_d = selected_trigger_input;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_prev_d;
        end
    end

    assign trig_rise = selected_trigger_input && !trig_prev_q;
    assign trig_fall = !selected_trigger_input && trig_prev_q;

    always_comb begin
        if (suspend_mode) begin
            trigger_event = trig_rise || trig_fall;
        end else if (trigger_falling_active) begin
            trigger_event = trig_fall;
        end else begin
            trigger_event = trig_rise;
        end
        trigger_event = trigger_event || sw_q[tef_pkg::SW_TRG];
    end

    // ===================================================
    // Overflow and channel events
    assign ovf_flag_ok = !overflow_event_disable && !overflow_source_select;
    assign overflow_event = hw_overflow || sw_q[tef_pkg::SW_OVF];
    assign ch_event = ch_hw_event
        | sw_q[tef_pkg::SW_CH_LSB +: NUM_CH];
    assign cap_evt = ch_event & ch_input_mode;

    // ===================================================
    // Flag set and clear terms
    always_comb begin
        fl_set = '0;
        fl_clr = '0;
        fl_set[tef_pkg::FL_OVF] = hw_overflow
            || (ovf_flag_ok && sw_q[tef_pkg::SW_OVF])
            || (ovf_flag_ok && cnt_reinit_by_trigger);
        fl_clr[tef_pkg::FL_OVF] = status_wr && wmask[tef_pkg::ST_OVF]
            && !pwdata[tef_pkg::ST_OVF];
        fl_set[tef_pkg::FL_TRG] = trigger_event;
        fl_clr[tef_pkg::FL_TRG] = status_wr && wmask[tef_pkg::ST_TRG]
            && !pwdata[tef_pkg::ST_TRG];
        for (int i = 0; i < NUM_CH; i++) begin
            // Capture in input mode, compare match in output mode
            fl_set[tef_pkg::FL_CH_LSB + i] = ch_event[i];
            fl_clr[tef_pkg::FL_CH_LSB + i] =
                (status_wr && wmask[tef_pkg::ST_CH_LSB + i]
                && !pwdata[tef_pkg::ST_CH_LSB + i])
                || (ch_input_mode[i] && ch_value_read[i]);
            fl_set[tef_pkg::FL_RCP_LSB + i] = cap_evt[i]
                && fl_q[tef_pkg::FL_CH_LSB + i];
            fl_clr[tef_pkg::FL_RCP_LSB + i] = status_wr
                && wmask[tef_pkg::ST_RCP_LSB + i]
                && !pwdata[tef_pkg::ST_RCP_LSB + i];
        end
    end

    tef_flag_bank #(
        .N(NF)
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set(fl_set),
        .clr(fl_clr),
        .flag_q(fl_q)
    );

    // ===================================================
    // Status assembly and read data
    always_comb begin
        status_v = tef_pkg::STATUS_RST;
        status_v[tef_pkg::ST_OVF] = fl_q[tef_pkg::FL_OVF];
        status_v[tef_pkg::ST_TRG] = fl_q[tef_pkg::FL_TRG];
        status_v[tef_pkg::ST_CH_LSB +: NUM_CH] =
            fl_q[tef_pkg::FL_CH_LSB +: NUM_CH];
        status_v[tef_pkg::ST_RCP_LSB +: NUM_CH] =
            fl_q[tef_pkg::FL_RCP_LSB +: NUM_CH];
        status_v = status_v & tef_pkg::STATUS_MASK;
    end

    assign event_status = status_v;

    // Read data captured in the setup cycle; write-only bits read zero
    always_comb begin
        rdata_d = rdata_q;
        if (setup_ph) begin
            rdata_d = tef_pkg::RDATA_RST;
            if (!pwrite && paddr == tef_pkg::STATUS_ADDR) begin
                rdata_d = {16'h0000, status_v};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= tef_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;

    // ===================================================
    // Assertions
    recap_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_evt[0] && event_status[tef_pkg::ST_CH_LSB]
        |=> event_status[tef_pkg::ST_RCP_LSB])
        else $error("recapture flag not set");

    recap_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        event_status[tef_pkg::ST_RCP_LSB + 3] && !status_wr
        |=> event_status[tef_pkg::ST_RCP_LSB + 3])
        else $error("recapture flag cleared without write");

    write_one_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        status_wr && pstrb[0] && pwdata[tef_pkg::ST_TRG]
        && event_status[tef_pkg::ST_TRG]
        |=> event_status[tef_pkg::ST_TRG])
        else $error("write of one cleared trigger flag");

    trig_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        trigger_event |=> event_status[tef_pkg::ST_TRG])
        else $error("trigger flag not set");

    suspend_edge_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        suspend_mode && $changed(selected_trigger_input)
        |-> trigger_event)
        else $error("suspend edge missed");

    read_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_input_mode[0] && ch_value_read[0] && !ch_event[0]
        |=> !event_status[tef_pkg::ST_CH_LSB])
        else $error("capture read did not clear flag");

    out_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ch_input_mode[1] && event_status[tef_pkg::ST_CH_LSB + 1]
        && !status_wr |=> event_status[tef_pkg::ST_CH_LSB + 1])
        else $error("output mode flag lost");

    ovf_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        status_wr && pstrb[0] && !pwdata[tef_pkg::ST_OVF]
        && !fl_set[tef_pkg::FL_OVF]
        |=> !event_status[tef_pkg::ST_OVF])
        else $error("overflow flag not cleared");

    reinit_ovf_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cnt_reinit_by_trigger && !overflow_event_disable
        && !overflow_source_select
        |=> event_status[tef_pkg::ST_OVF])
        else $error("reinit did not set overflow flag");

    sw_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        swevt_wr && pstrb[0] && pwdata[tef_pkg::SW_CH_LSB]
        |=> ch_event[0] ##1 (ch_event[0] == ch_hw_event[0]))
        else $error("software channel event not one cycle");

    sw_ovf_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        swevt_wr && pstrb[0] && pwdata[tef_pkg::SW_OVF]
        && !overflow_event_disable && !overflow_source_select
        |=> overflow_event ##1 event_status[tef_pkg::ST_OVF])
        else $error("software overflow not flagged");

    set_wins_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        hw_overflow && status_wr && pstrb[0] && !pwdata[tef_pkg::ST_OVF]
        |=> event_status[tef_pkg::ST_OVF])
        else $error("clear beat hardware set");

    resd_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access_ph |-> (prdata & ~{16'h0000, tef_pkg::STATUS_MASK})
        == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    ch_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_event[2] |=> event_status[tef_pkg::ST_CH_LSB + 2])
        else $error("channel 3 flag not set");

    cap_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ch_input_mode[0] && ch_hw_event[0]
        |=> event_status[tef_pkg::ST_CH_LSB])
        else $error("capture did not set channel flag");

    sw_trig_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        swevt_wr && pstrb[0] && pwdata[tef_pkg::SW_TRG]
        |=> trigger_event)
        else $error("software trigger not generated");
endmodule

`default_nettype wire

// *** tef_flag_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

// Bank of sticky flags; a set in the same cycle as a clear wins
module tef_flag_bank #(
    parameter int N = 10
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic [N-1:0] set, // Set request per flag
    input wire logic [N-1:0] clr, // Clear request per flag
    output logic [N-1:0] flag_q // Flag values
);
    logic [N-1:0] flag_d;

    always_comb begin
        flag_d = (flag_q & ~clr) | set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule

`default_nettype wire

// *** tef_pkg.sv ***
package tef_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_CH = 4;
    localparam int NUM_FLAGS = 10;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] SWEVT_ADDR = 12'h004;

    // Status register bit positions
    localparam int ST_OVF = 0;
    localparam int ST_CH_LSB = 1;
    localparam int ST_TRG = 6;
    localparam int ST_RCP_LSB = 9;

    // Software event register bit positions
    localparam int SW_OVF = 0;
    localparam int SW_CH_LSB = 1;
    localparam int SW_TRG = 6;
    localparam int SW_W = 7;

    // Internal flag vector layout
    localparam int FL_OVF = 0;
    localparam int FL_CH_LSB = 1;
    localparam int FL_TRG = 5;
    localparam int FL_RCP_LSB = 6;

    localparam logic [15:0] STATUS_MASK = 16'h1e5f;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [SW_W-1:0] SWEVT_MASK = 7'h5f;
    localparam logic [SW_W-1:0] SWEVT_RST = 7'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage
